// ==== design/clf_cfg.svh ====
// Register offsets, field positions, reset values and timing counts
// for the colour LED flash controller.
// Assumes a 100 MHz system clock.
`ifndef CLF_CFG_SVH
`define CLF_CFG_SVH

// Serial address; the value is arbitrary.
`define CLF_DEV_ADDR       7'h2a

// Register offsets.
`define CLF_OFS_CTRL       8'h00
`define CLF_OFS_COLOR      8'h01
`define CLF_OFS_CURR       8'h02
`define CLF_OFS_GPIO       8'h06
`define CLF_OFS_SAFETY     8'h07

// Control register fields.
`define CLF_CTRL_INT_MOD   7
`define CLF_CTRL_COLOR_EN  6
`define CLF_CTRL_MODE_SEL  5
`define CLF_CTRL_RED_ON    3
`define CLF_CTRL_GREEN_ON  2
`define CLF_CTRL_BLUE_ON   1
`define CLF_CTRL_MASK      8'hee

// Current limit fields: red 5:4, green 3:2, blue 1:0.
`define CLF_CURR_MASK      8'h3f

// Pin control: pin enable 4, external selects red 2, green 1, blue 0.
`define CLF_GPIO_PIN_EN    4
`define CLF_GPIO_MASK      8'h17

// Safety register: tripped 7 (read only), flash mode 3,
// safety enables red 2, green 1, blue 0.
`define CLF_SAFE_TRIPPED   7
`define CLF_SAFE_FLASH     3
`define CLF_SAFE_MASK      8'h0f

// Reset values; switch mode is the default output mode.
`define CLF_CTRL_RESET     8'h20
`define CLF_ZERO_RESET     8'h00

// Full scale current code.
`define CLF_CODE_FULL      2'h3

// Safety interval.
`define CLF_SAFETY_TIME_MS 1000
`define CLF_CLK_KHZ        100000
`define CLF_SAFETY_CYCLES  (`CLF_SAFETY_TIME_MS * `CLF_CLK_KHZ)

`endif

// ==== design/clf_pkg.sv ====
// Types shared by the colour LED flash controller.
// Assumes nothing beyond the configuration header.
package clf_pkg;

  // Serial slave states.
  typedef enum logic [3:0] {
    CLF_IDLE   = 4'h0,
    CLF_ADDR   = 4'h1,
    CLF_ACK_A  = 4'h2,
    CLF_PTR    = 4'h3,
    CLF_ACK_P  = 4'h4,
    CLF_WDATA  = 4'h5,
    CLF_ACK_W  = 4'h6,
    CLF_RDATA  = 4'h7,
    CLF_ACK_R  = 4'h8
  } clf_i2c_state_t;

endpackage

// ==== design/clf_led_channel.sv ====
// One colour output channel: on/off decision and current code.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

`include "clf_cfg.svh"

module clf_led_channel
  import clf_pkg::*;
(
  input  wire logic       color_en_i,  // Colour outputs enabled.
  input  wire logic       int_mod_i,   // Internal modulation enabled.
  input  wire logic       on_i,        // Output on/off enable bit.
  input  wire logic [1:0] code_i,      // Programmed current code.
  input  wire logic       ext_sel_i,   // External pin governs output.
  input  wire logic       ext_act_i,   // External pin function active.
  input  wire logic       ext_lvl_i,   // Synchronised pin level.
  input  wire logic       int_pwm_i,   // Internal modulation waveform.
  input  wire logic       flash_i,     // Flash mode enabled.
  input  wire logic       done_i,      // Flash pulse already spent.
  input  wire logic       kill_i,      // Safety shut-off for output.
  output logic            drive_o,     // Output sinks when high.
  output logic [1:0]      code_o       // Effective current code.
);

  logic gated;
  logic base;

  // Pin gating: a high pin lets the output conduct.
  always_comb
  begin
    gated = 1'b1;
    if (ext_act_i && ext_sel_i && !flash_i)
      gated = ext_lvl_i; // R6 R7 R8 R9
  end

  // The waveform only matters when internal modulation is on.
  assign base = color_en_i && on_i && (int_mod_i ? int_pwm_i : 1'b1); // R2 R3 R8

  // Flash pulse overrides both the enable bit and the code.
  always_comb
  begin
    drive_o = base && gated;
    code_o  = code_i; // R5
    if (flash_i && ext_sel_i && ext_act_i)
    begin
      if (ext_lvl_i && !done_i)
      begin
        drive_o = color_en_i; // R10
        code_o  = `CLF_CODE_FULL; // R10
      end
      else if (done_i)
        drive_o = 1'b0; // R11
    end
    if (kill_i)
      drive_o = 1'b0; // R16 R17 R18
  end

endmodule // clf_led_channel

`default_nettype wire

// ==== design/clf_color_led_flash.sv ====
// Colour LED flash controller: serial register slave, output
// control for three channels and the safety timer.
// Assumes the serial pins and trigger pin are asynchronous and the
// internal modulation waveform comes from the system clock domain.
//
// Contract
// R1 - Control bits: modulation 7, colour enable 6, mode 5, on bits 3..1.
// R2 - Colour enabled, modulation off: each on bit switches its output directly.
// R3 - In direct mode the colour register affects nothing.
// R4 - Mode bit high means switch, low current sink; reset gives switch.
// R5 - Current code fields 5:4, 3:2, 1:0 pick quarter steps of maximum.
// R6 - Pin function active only with pin enable and colour enable; selects.
// R7 - Pin is active high: high enables selected outputs.
// R8 - Without modulation pin drives output; with it, pin gates waveform.
// R9 - Enabled output with select clear stays on regardless of pin.
// R10 - Flash pulse high: selected outputs full current, ignore code and on.
// R11 - After pulse flash outputs off until flash mode cleared and set.
// R12 - Host sets codes, colour, flash mode with pin low, then pulses.
// R13 - Register flash: current mode, low codes, on, full codes, off.
// R14 - Each output has a safety bit; flash mode picks timer mode.
// R15 - Flash off: counter runs with any safety bit; current access clears.
// R16 - Flash off: one second kills safety outputs and sets tripped flag.
// R17 - Flash on: counts while pin high; long pulse kills and trips.
// R18 - Clearing own safety bit restores output; counter clears with all.
// R19 - One second counted in system clock cycles, held zero when cleared.
// R20 - Tripped flag holds until all safety bits clear, ignores writes.
`timescale 1ns/1ps
`default_nettype none

`include "clf_cfg.svh"

module clf_color_led_flash
  import clf_pkg::*;
#(
  parameter int unsigned SAFETY_CYCLES = `CLF_SAFETY_CYCLES
)
(
  input  wire logic       clk_sys_i,          // 100 MHz clock.
  input  wire logic       rst_b_i,            // Sync reset, low.
  input  wire logic       scl_i,              // Serial clock pin.
  input  wire logic       sda_i,              // Serial data pin in.
  output logic            sda_o,              // Serial data out.
  output logic            sda_oe_b_o,         // Low while driving.
  input  wire logic       ext_pwm_i,          // Trigger/PWM pin.
  input  wire logic [2:0] int_pwm_i,          // Internal waveform rgb.
  output logic            red_output_o,       // Red sinks.
  output logic            green_output_o,     // Green sinks.
  output logic            blue_output_o,      // Blue sinks.
  output logic [1:0]      red_current_code_o, // Red code.
  output logic [1:0]      green_current_code_o, // Green code.
  output logic [1:0]      blue_current_code_o, // Blue code.
  output logic            output_mode_select_o, // High is switch.
  output logic            internal_modulation_enable_o, // Mod on.
  output logic [7:0]      color_brightness_o, // Colour register.
  output logic            safety_tripped_o    // Safety shut-off.
);

  localparam logic [26:0] SAFE_LAST = 27'(SAFETY_CYCLES - 1);

  clf_i2c_state_t state_reg;
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [1:0]  ext_sync_reg;
  logic        ext_prev_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [3:0]  cnt_reg;
  logic        rw_reg;
  logic        nack_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  color_reg;
  logic [7:0]  led_current_limit_reg;
  logic [7:0]  gpio_reg;
  logic [3:0]  safety_reg;
  logic        tripped_reg;
  logic        done_reg;
  logic [26:0] safe_cnt_reg;
  logic        wr_stb;
  logic        curr_access;
  logic [7:0]  rd_data;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        ext_lvl;
  logic        ext_act;
  logic        flash_mode;
  logic        any_safe;
  logic        counting;
  logic [2:0]  drive;
  logic [5:0]  code;

  // Two flops before use; the third stage is only an edge history.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      ext_sync_reg <= {ext_sync_reg[0], ext_pwm_i};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  assign scl_rise  = scl_sync_reg[1] && !scl_sync_reg[2];
  assign scl_fall  = !scl_sync_reg[1] && scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] && scl_sync_reg[2] &&
                     !sda_sync_reg[1] && sda_sync_reg[2];
  assign stop_det  = scl_sync_reg[1] && scl_sync_reg[2] &&
                     sda_sync_reg[1] && !sda_sync_reg[2];
  assign ext_lvl   = ext_sync_reg[1];

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    rd_data = 8'h00;
    unique case (ptr_reg)
      `CLF_OFS_CTRL:   rd_data = ctrl_reg;
      `CLF_OFS_COLOR:  rd_data = color_reg;
      `CLF_OFS_CURR:   rd_data = led_current_limit_reg;
      `CLF_OFS_GPIO:   rd_data = gpio_reg;
      `CLF_OFS_SAFETY: rd_data = {tripped_reg, 3'h0, safety_reg};
      default:         rd_data = 8'h00;
    endcase
  end

  assign wr_stb = scl_fall && (state_reg == CLF_WDATA) && (cnt_reg == 4'h8);
  // A data byte written, or a read byte loaded, at the limit register.
  assign curr_access = (ptr_reg == `CLF_OFS_CURR) &&
    (wr_stb || (scl_fall && ((state_reg == CLF_ACK_A && rw_reg) ||
                             (state_reg == CLF_ACK_R && !nack_reg))));

  // Serial slave: sample on rising clock, change data on falling.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      state_reg  <= CLF_IDLE;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      cnt_reg    <= 4'h0;
      rw_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      ptr_reg    <= 8'h00;
      sda_oe_b_o <= 1'b1;
    end
    else if (start_det)
    begin
      state_reg  <= CLF_ADDR;
      cnt_reg    <= 4'h0;
      sda_oe_b_o <= 1'b1;
    end
    else if (stop_det)
    begin
      state_reg  <= CLF_IDLE;
      sda_oe_b_o <= 1'b1;
    end
    else if (scl_rise)
    begin
      if (state_reg == CLF_ACK_R)
        nack_reg <= sda_sync_reg[1];
      else if (state_reg == CLF_ADDR || state_reg == CLF_PTR ||
               state_reg == CLF_WDATA)
      begin
        shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
        cnt_reg   <= cnt_reg + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (state_reg)
        CLF_IDLE: ;
        CLF_ADDR:
          if (cnt_reg == 4'h8)
          begin
            if (shift_reg[7:1] == `CLF_DEV_ADDR)
            begin
              rw_reg     <= shift_reg[0];
              sda_oe_b_o <= 1'b0;
              state_reg  <= CLF_ACK_A;
            end
            else
              state_reg <= CLF_IDLE;
          end
        CLF_ACK_A, CLF_ACK_R:
        begin
          cnt_reg <= 4'h0;
          if (state_reg == CLF_ACK_R && nack_reg)
          begin
            sda_oe_b_o <= 1'b1;
            state_reg  <= CLF_IDLE;
          end
          else if (rw_reg)
          begin
            tx_reg     <= {rd_data[6:0], 1'b0};
            sda_oe_b_o <= rd_data[7];
            state_reg  <= CLF_RDATA;
          end
          else
          begin
            sda_oe_b_o <= 1'b1;
            state_reg  <= CLF_PTR;
          end
        end
        CLF_PTR:
          if (cnt_reg == 4'h8)
          begin
            ptr_reg    <= shift_reg;
            sda_oe_b_o <= 1'b0;
            state_reg  <= CLF_ACK_P;
          end
        CLF_ACK_P, CLF_ACK_W:
        begin
          cnt_reg    <= 4'h0;
          sda_oe_b_o <= 1'b1;
          state_reg  <= CLF_WDATA;
        end
        CLF_WDATA:
          if (cnt_reg == 4'h8)
          begin
            ptr_reg    <= ptr_reg + 8'h01;
            sda_oe_b_o <= 1'b0;
            state_reg  <= CLF_ACK_W;
          end
        CLF_RDATA:
          if (cnt_reg == 4'h7)
          begin
            sda_oe_b_o <= 1'b1;
            ptr_reg    <= ptr_reg + 8'h01;
            state_reg  <= CLF_ACK_R;
          end
          else
          begin
            sda_oe_b_o <= tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b0};
            cnt_reg    <= cnt_reg + 4'h1;
          end
        default: state_reg <= CLF_IDLE;
      endcase
    end
  end

  // The data line is only ever pulled low.
  always_ff @(posedge clk_sys_i)
  begin
    sda_o <= 1'b0;
  end

  // Register file writes; reserved bits are masked to zero.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg              <= `CLF_CTRL_RESET; // R4
      color_reg             <= `CLF_ZERO_RESET;
      led_current_limit_reg <= `CLF_ZERO_RESET;
      gpio_reg              <= `CLF_ZERO_RESET;
      safety_reg            <= 4'h0;
    end
    else if (wr_stb)
    begin
      unique case (ptr_reg)
        `CLF_OFS_CTRL:   ctrl_reg <= shift_reg & `CLF_CTRL_MASK; // R1
        `CLF_OFS_COLOR:  color_reg <= shift_reg;
        `CLF_OFS_CURR:   led_current_limit_reg <= shift_reg & `CLF_CURR_MASK;
        `CLF_OFS_GPIO:   gpio_reg <= shift_reg & `CLF_GPIO_MASK;
        `CLF_OFS_SAFETY: safety_reg <= shift_reg[3:0]; // R14 R20
        default: ;
      endcase
    end
  end

  assign flash_mode = safety_reg[`CLF_SAFE_FLASH]; // R14
  assign any_safe   = |safety_reg[2:0];
  assign ext_act    = gpio_reg[`CLF_GPIO_PIN_EN] &&
                      ctrl_reg[`CLF_CTRL_COLOR_EN]; // R6

  // A pulse is spent on its falling edge; re-arm by clearing flash mode.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || !flash_mode)
      done_reg <= 1'b0; // R11
    else if (ext_act && ext_prev_reg && !ext_lvl)
      done_reg <= 1'b1; // R11
  end

  // Safety timer in system clock cycles.
  assign counting = !tripped_reg &&
                    (flash_mode ? (ext_lvl && !done_reg) : any_safe); // R15 R17

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || !any_safe)
      safe_cnt_reg <= 27'h0; // R18 R19
    else if (!tripped_reg && !flash_mode && curr_access)
      safe_cnt_reg <= 27'h0; // R15
    else if (flash_mode && ext_lvl && !ext_prev_reg && !tripped_reg)
      safe_cnt_reg <= 27'h0; // R17
    else if (counting && safe_cnt_reg != SAFE_LAST)
      safe_cnt_reg <= safe_cnt_reg + 27'h1; // R19
  end

  // Trip wins over the clear: it can only clear once no bit is enabled.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      tripped_reg <= 1'b0;
    else if (counting && safe_cnt_reg == SAFE_LAST)
      tripped_reg <= 1'b1; // R16 R17
    else if (!any_safe)
      tripped_reg <= 1'b0; // R18 R20
  end

  // Three identical output channels, red at index 2.
  for (genvar i = 0; i < 3; i++)
  begin : g_chan
    clf_led_channel u_chan (
      .color_en_i (ctrl_reg[`CLF_CTRL_COLOR_EN]),
      .int_mod_i  (ctrl_reg[`CLF_CTRL_INT_MOD]),
      .on_i       (ctrl_reg[`CLF_CTRL_BLUE_ON + i]),
      .code_i     (led_current_limit_reg[2*i +: 2]),
      .ext_sel_i  (gpio_reg[i]),
      .ext_act_i  (ext_act),
      .ext_lvl_i  (ext_lvl),
      .int_pwm_i  (int_pwm_i[i]),
      .flash_i    (flash_mode),
      .done_i     (done_reg),
      .kill_i     (tripped_reg && safety_reg[i]),
      .drive_o    (drive[i]),
      .code_o     (code[2*i +: 2])
    );
  end

  // Registered outputs so pins never glitch on decode paths.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      red_output_o                 <= 1'b0;
      green_output_o               <= 1'b0;
      blue_output_o                <= 1'b0;
      red_current_code_o           <= 2'h0;
      green_current_code_o         <= 2'h0;
      blue_current_code_o          <= 2'h0;
      output_mode_select_o         <= 1'b1;
      internal_modulation_enable_o <= 1'b0;
      color_brightness_o           <= 8'h00;
      safety_tripped_o             <= 1'b0;
    end
    else
    begin
      red_output_o                 <= drive[2];
      green_output_o               <= drive[1];
      blue_output_o                <= drive[0];
      red_current_code_o           <= code[5:4];
      green_current_code_o         <= code[3:2];
      blue_current_code_o          <= code[1:0];
      output_mode_select_o         <= ctrl_reg[`CLF_CTRL_MODE_SEL]; // R4
      internal_modulation_enable_o <= ctrl_reg[`CLF_CTRL_INT_MOD];
      color_brightness_o           <= color_reg;
      safety_tripped_o             <= tripped_reg;
    end
  end

endmodule // clf_color_led_flash

`default_nettype wire

// ==== sim/clf_host_model.sv ====
// Serial host model: a bit-banged bus master.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none

`include "clf_cfg.svh"

module clf_host_model
(
  input  wire logic clk_i,     // Bench clock.
  input  wire logic sda_i,     // Resolved data line.
  output logic      scl_o,     // Serial clock pin.
  output logic      sda_low_o  // High pulls the data line low.
);
  int hold     = 6;  // Clock high phase.
  int ack_errs = 0;  // Missing acknowledges seen.

  // Both lines are released while idle.
  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Also a repeated start; the pause avoids a false stop.
  task automatic start();
    tick(2);
    sda_low_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(hold);
    sda_low_o <= 1'b1;
    tick(hold);
    scl_o <= 1'b0;
  endtask

  // Data moves while the clock is low.
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_low_o <= ~b;
    tick(4);
    scl_o <= 1'b1;
    tick(hold);
    s = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic rd,
                         output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    if (!rd && a !== 1'b0)
      ack_errs++;
  endtask

  task automatic stop();
    tick(2);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(hold);
    sda_low_o <= 1'b0;
    tick(hold);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({`CLF_DEV_ADDR, 1'b0}, 1'b0, q);
    byte_io(ofs, 1'b0, q);
    byte_io(d, 1'b0, q);
    stop();
  endtask

  // One byte read, ended by a not-acknowledge.
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({`CLF_DEV_ADDR, 1'b0}, 1'b0, q);
    byte_io(ofs, 1'b0, q);
    start();
    byte_io({`CLF_DEV_ADDR, 1'b1}, 1'b0, q);
    byte_io(8'hff, 1'b1, d);
    stop();
  endtask
endmodule // clf_host_model

`default_nettype wire

// ==== sim/clf_color_led_flash_monitor.sv ====
// Checker for the colour LED flash controller, bound to its ports.
// Assumes serial clock phases of at least four system cycles.
`timescale 1ns/1ps
`default_nettype none

module clf_color_led_flash_monitor
#(
  parameter int unsigned SAFETY_CYCLES = 100
)
(
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_b_o,
  input wire logic       ext_pwm_i,
  input wire logic [2:0] int_pwm_i,
  input wire logic       red_output_o,
  input wire logic       green_output_o,
  input wire logic       blue_output_o,
  input wire logic [1:0] red_current_code_o,
  input wire logic [1:0] green_current_code_o,
  input wire logic [1:0] blue_current_code_o,
  input wire logic       output_mode_select_o,
  input wire logic       internal_modulation_enable_o,
  input wire logic [7:0] color_brightness_o,
  input wire logic       safety_tripped_o
);
  logic [7:0]  scl_gap_reg;  // Cycles since the serial clock fell.
  logic [7:0]  ext_gap_reg;  // Cycles since the trigger pin moved.
  logic [31:0] run_reg;      // Cycles since reset, saturating.
  logic        scl_d_reg;
  logic        ext_d_reg;

  // Distances to the causes that may move the registered outputs.
  always_ff @(posedge clk_sys_i)
  begin
    scl_d_reg <= scl_i;
    ext_d_reg <= ext_pwm_i;
    if (!rst_b_i)
    begin
      scl_gap_reg <= 8'hff;
      ext_gap_reg <= 8'hff;
      run_reg     <= 32'h0;
    end
    else
    begin
      if (scl_d_reg && !scl_i)
        scl_gap_reg <= 8'h00;
      else if (scl_gap_reg != 8'hff)
        scl_gap_reg <= scl_gap_reg + 8'h01;
      if (ext_d_reg != ext_pwm_i)
        ext_gap_reg <= 8'h00;
      else if (ext_gap_reg != 8'hff)
        ext_gap_reg <= ext_gap_reg + 8'h01;
      if (run_reg < SAFETY_CYCLES)
        run_reg <= run_reg + 32'h1;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_mod_gates_red: assert property (
    red_output_o && internal_modulation_enable_o && red_current_code_o != 2'h3
    |-> $past(int_pwm_i[2]) || $past(int_pwm_i[2], 2))
    else $error("red on, waveform low");
  chk_mod_gates_blue: assert property (
    blue_output_o && internal_modulation_enable_o &&
    blue_current_code_o != 2'h3
    |-> $past(int_pwm_i[0]) || $past(int_pwm_i[0], 2))
    else $error("blue on, waveform low");
  chk_trip_wait: assert property (
    $rose(safety_tripped_o) |-> run_reg >= SAFETY_CYCLES - 1)
    else $error("early safety trip");
  chk_trip_holds: assert property (
    $rose(safety_tripped_o) |=> safety_tripped_o [*4])
    else $error("trip flag dropped");
  chk_trip_by_write: assert property (
    $fell(safety_tripped_o) |-> scl_gap_reg <= 8'd8)
    else $error("trip cleared, no write");
  chk_cfg_by_write: assert property (
    $changed({output_mode_select_o, internal_modulation_enable_o,
              color_brightness_o}) |-> scl_gap_reg <= 8'd8)
    else $error("control moved, no write");
  chk_code_cause: assert property (
    ($changed(red_current_code_o) || $changed(blue_current_code_o)) &&
    $stable(safety_tripped_o) &&
    safety_tripped_o == $past(safety_tripped_o, 2)
    |-> scl_gap_reg <= 8'd8 || ext_gap_reg <= 8'd6)
    else $error("code moved, no cause");
  chk_ack_scl_low: assert property (
    $changed(sda_oe_b_o) |-> !scl_i)
    else $error("data moved, clock high");
  chk_sda_out_zero: assert property (
    sda_o == 1'b0)
    else $error("data out high");

  cover property ($rose(safety_tripped_o));
  cover property (red_output_o && red_current_code_o == 2'h3);
  cover property ($fell(sda_oe_b_o));
endmodule // clf_color_led_flash_monitor

`default_nettype wire

// ==== sim/tb.sv ====
// Bench top: host model, pins and checks.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

`include "clf_cfg.svh"
`define CHK(g, e) check_eq(8'(g), 8'(e))

module tb;
  localparam int unsigned SC = 3000;  // Shortened safety interval.

  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        ext_q     = 1'b0;
  logic [2:0]  pwm_q     = 3'h0;
  logic        scl, host_low, sda_o, sda_oe_b, sda_line;
  logic        red, green, blue, mode_sel, int_mod, tripped;
  logic [1:0]  rc, gc, bc;
  logic [7:0]  color;
  logic [31:0] lfsr_q    = 32'h667a;
  int          miscompares     = 0;
  int          samples_checked = 0;

  // Open-drain data line with a pull-up.
  assign sda_line = (sda_oe_b ? 1'b1 : sda_o) & ~host_low;

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  clf_host_model host (.clk_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl),
                       .sda_low_o(host_low));

  clf_color_led_flash #(.SAFETY_CYCLES(SC)) uut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b),
    .ext_pwm_i(ext_q), .int_pwm_i(pwm_q), .red_output_o(red),
    .green_output_o(green), .blue_output_o(blue),
    .red_current_code_o(rc), .green_current_code_o(gc),
    .blue_current_code_o(bc), .output_mode_select_o(mode_sel),
    .internal_modulation_enable_o(int_mod),
    .color_brightness_o(color), .safety_tripped_o(tripped));

  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic outs(input logic [2:0] e);
    `CHK({red, green, blue}, e);
  endtask

  function automatic logic [7:0] rnd();
    lfsr_q = lfsr_q[0] ? (lfsr_q >> 1) ^ 32'h80200003 : lfsr_q >> 1;
    return lfsr_q[7:0];
  endfunction

  // Expected outputs, flash mode off.
  function automatic logic [2:0] exp_out(input logic [7:0] c, g,
                                         input logic e, input logic [2:0] p);
    logic [2:0] on;
    logic [2:0] gate;
    on   = {c[3], c[2], c[1]} & {3{c[6]}};
    gate = (g[4] && c[6]) ? (~g[2:0] | {3{e}}) : 3'h7;
    return on & (c[7] ? p : 3'h7) & gate;
  endfunction

  initial
  begin
    logic [7:0] c, g, k, v;
    cyc(5);
    rst_b_i <= 1'b1;
    cyc(3);
    outs(3'h0);
    `CHK({mode_sel, tripped}, 2'b10);
    host.rd(`CLF_OFS_CTRL, v);
    `CHK(v, `CLF_CTRL_RESET);
    host.rd(8'h05, v);
    `CHK(v, 8'h00);
    // Random states; the first control and pin values are fixed.
    for (int i = 0; i < 16; i++)
    begin
      c = (i == 0) ? 8'h4e : rnd() & `CLF_CTRL_MASK;
      g = (i == 0) ? 8'h15 : rnd() & `CLF_GPIO_MASK;
      k = rnd();
      v = rnd();
      host.hold = (i % 4 == 3) ? 12 : 6;
      host.wr(`CLF_OFS_CTRL, c);
      host.wr(`CLF_OFS_GPIO, g);
      host.wr(`CLF_OFS_CURR, k);
      host.wr(`CLF_OFS_COLOR, v);
      ext_q <= v[0];
      pwm_q <= k[7:5];
      cyc(6);
      outs(exp_out(c, g, v[0], k[7:5]));
      `CHK({mode_sel, int_mod}, {c[5], c[7]});
      `CHK({rc, gc, bc}, k[5:0]);
      `CHK(color, v);
      host.rd(`CLF_OFS_CTRL, v);
      `CHK(v, c);
    end
    // Flash: override, one shot, re-arm with the red on bit clear.
    ext_q <= 1'b0;
    host.wr(`CLF_OFS_CURR, 8'h00);
    host.wr(`CLF_OFS_CTRL, 8'h4e);
    host.wr(`CLF_OFS_SAFETY, 8'h08);
    host.wr(`CLF_OFS_GPIO, 8'h14);
    for (int p = 0; p < 3; p++)
    begin
      if (p == 2)
      begin
        host.wr(`CLF_OFS_CTRL, 8'h46);
        host.wr(`CLF_OFS_SAFETY, 8'h00);
        host.wr(`CLF_OFS_SAFETY, 8'h08);
      end
      cyc(6);
      outs(p == 2 ? 3'h3 : (p == 1 ? 3'h3 : 3'h7));
      ext_q <= 1'b1;
      cyc(6);
      outs(p == 1 ? 3'h3 : 3'h7);
      if (p != 1)
        `CHK({rc, gc}, 4'hc);
      ext_q <= 1'b0;
    end
    // Long flash pulse trips the red safety.
    cyc(6);
    host.wr(`CLF_OFS_SAFETY, 8'h00);
    host.wr(`CLF_OFS_SAFETY, 8'h0c);
    ext_q <= 1'b1;
    cyc(SC - 50);
    `CHK({tripped, red}, 2'b01);
    cyc(60);
    `CHK({tripped, red, green}, 3'b101);
    ext_q <= 1'b0;
    host.wr(`CLF_OFS_SAFETY, 8'h08);
    `CHK(tripped, 1'b0);
    // Flash off: limit accesses hold off the trip.
    host.wr(`CLF_OFS_GPIO, 8'h00);
    host.wr(`CLF_OFS_CTRL, 8'h4e);
    host.wr(`CLF_OFS_SAFETY, 8'h02);
    for (int j = 0; j < 4; j++)
    begin
      cyc(SC / 3);
      if (j % 2 == 1)
        host.rd(`CLF_OFS_CURR, v);
      else
        host.wr(`CLF_OFS_CURR, 8'h15);
      `CHK(tripped, 1'b0);
    end
    cyc(SC + 20);
    `CHK(tripped, 1'b1);
    outs(3'h5);
    host.wr(`CLF_OFS_CURR, 8'h15);
    host.wr(`CLF_OFS_SAFETY, 8'h02);
    `CHK(tripped, 1'b1);
    host.rd(`CLF_OFS_SAFETY, v);
    `CHK(v, 8'h82);
    host.wr(`CLF_OFS_SAFETY, 8'h00);
    cyc(4);
    `CHK(tripped, 1'b0);
    outs(3'h7);
    `CHK(host.ack_errs, 0);
    final_report();
  end

  // A hang ends the run as a mismatch.
  initial
  begin
    cyc(95000);
    miscompares++;
    final_report();
  end
endmodule // tb

bind clf_color_led_flash clf_color_led_flash_monitor #(
  .SAFETY_CYCLES(SAFETY_CYCLES)
) mon (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
  .ext_pwm_i(ext_pwm_i), .int_pwm_i(int_pwm_i),
  .red_output_o(red_output_o), .green_output_o(green_output_o),
  .blue_output_o(blue_output_o), .red_current_code_o(red_current_code_o),
  .green_current_code_o(green_current_code_o),
  .blue_current_code_o(blue_current_code_o),
  .output_mode_select_o(output_mode_select_o),
  .internal_modulation_enable_o(internal_modulation_enable_o),
  .color_brightness_o(color_brightness_o),
  .safety_tripped_o(safety_tripped_o));

`default_nettype wire
